// ==== verilog/smf_regs.svh ====
`ifndef SMF_REGS_SVH
`define SMF_REGS_SVH

// Overrange headroom: 5% is one twentieth of full scale
`define SMF_OVR_DIV 20

`define SMF_GBW_MIN_HZ 32'h0000000a
`define SMF_GBW_MAX_HZ 32'h001e8480
`define SMF_CFREQ_MIN_HZ 32'h00000032
`define SMF_CFREQ_MAX_HZ 32'h000f4240
// Pole-zero ratio in unsigned 4.12 fixed point
`define SMF_PZ_MIN 16'h0200
`define SMF_PZ_MAX 16'h8000

`define SMF_RST_GBW 32'h00002710
`define SMF_RST_CFREQ 32'h000003e8
`define SMF_RST_PZ 16'h1000

`define SMF_CLK_NS 10
`define SMF_SETTLE_NS 2000
`define SMF_SETTLE_CYC ((`SMF_SETTLE_NS + `SMF_CLK_NS - 1) / `SMF_CLK_NS)
`define SMF_AR_AUTO_SHIFT 2

`endif

// ==== verilog/smf_pkg.sv ====
`include "smf_regs.svh"
package smf_pkg;
  typedef enum logic {SMF_PROF_NORMAL, SMF_PROF_SECOND} smf_profile_t;
  typedef enum logic [1:0] {SMF_CMP_GBW, SMF_CMP_FREQ, SMF_CMP_PZ} smf_cmp_sel_t;
  typedef enum logic {SMF_SRC_VOLT, SMF_SRC_CURR} smf_src_t;
  typedef enum logic {SMF_DIV_IDLE, SMF_DIV_RUN} smf_div_state_t;

  function automatic logic [32:0] smf_ovr_limit(input logic [31:0] fs, input logic en);
    logic [32:0] extra;
    extra = en ? 33'(fs / 32'(`SMF_OVR_DIV)) : 33'h0;
    return {1'b0, fs} + extra;
  endfunction
endpackage

// ==== verilog/smf_range_pick.sv ====
`timescale 1ns/1ps
module smf_range_pick #(
  parameter int NR = 4,
  parameter int VW = 24,
  parameter int IW = 2
) (
  input wire logic [NR*VW-1:0] range_fs,
  input wire logic overrange_en,
  input wire logic [VW-1:0] value,
  output logic fits_any,
  output logic [IW-1:0] best
);
  import smf_pkg::*;

  // Ranges ascend, so the last hit walking down is the smallest
  always_comb begin
    fits_any = 1'b0;
    best = '0;
    for (int r = NR - 1; r >= 0; r--) begin
      if ({1'b0, 32'(value)} <= smf_ovr_limit(32'(range_fs[r*VW +: VW]), overrange_en)) begin
        fits_any = 1'b1;
        best = IW'(r);
      end
    end
  end
endmodule

// ==== verilog/smf_div.sv ====
`timescale 1ns/1ps
module smf_div #(
  parameter int NW = 56,
  parameter int DW = 32,
  parameter int QW = 24
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic signed [NW-1:0] num,
  input wire logic [DW-1:0] den,
  output logic signed [QW-1:0] quo,
  output logic done
);
  import smf_pkg::*;

  typedef struct packed {
    smf_div_state_t state;
    logic [$clog2(NW+1)-1:0] cnt;
    logic [NW-1:0] dvd;
    logic [DW:0] rem;
    logic [DW-1:0] den;
    logic neg;
    logic signed [QW-1:0] quo;
    logic done;
  } smf_div_st_t;

  smf_div_st_t st, next_st;
  logic [DW:0] trial;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    trial = '0;
    case (st.state)
      SMF_DIV_IDLE: begin
        if (start) begin
          next_st.state = SMF_DIV_RUN;
          next_st.neg = num[NW-1];
          next_st.dvd = num[NW-1] ? NW'(-num) : num;
          next_st.den = den;
          next_st.rem = '0;
          next_st.cnt = '0;
        end
      end
      SMF_DIV_RUN: begin
        // Restoring division, one quotient bit per cycle
        trial = {st.rem[DW-1:0], st.dvd[NW-1]};
        next_st.dvd = {st.dvd[NW-2:0], 1'b0};
        if (trial >= {1'b0, st.den}) begin
          next_st.rem = trial - {1'b0, st.den};
          next_st.dvd[0] = 1'b1;
        end else begin
          next_st.rem = trial;
        end
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt == ($clog2(NW+1))'(NW - 1)) begin
          next_st.state = SMF_DIV_IDLE;
          next_st.done = 1'b1;
          next_st.quo = st.neg ? -QW'({next_st.dvd}) : QW'(next_st.dvd);
        end
      end
      default: next_st.state = SMF_DIV_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign quo = st.quo;
  assign done = st.done;
endmodule

// ==== verilog/smf_measure_filter.sv ====
`timescale 1ns/1ps
`include "smf_regs.svh"
module smf_measure_filter #(
  parameter int SW = 24,
  parameter int AW = 16,
  parameter int NR = 4,
  parameter int UNIT = 4,
  parameter logic [NR*SW-1:0] V_RANGES = {24'h0f4240, 24'h0186a0, 24'h002710, 24'h0003e8},
  parameter logic [NR*SW-1:0] I_RANGES = {24'h0f4240, 24'h0186a0, 24'h002710, 24'h0003e8}
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic acq_run,
  input wire logic sample_valid,
  input wire logic signed [SW-1:0] volt_sample,
  input wire logic signed [SW-1:0] curr_sample,
  input wire smf_pkg::smf_profile_t noise_profile,
  input wire logic [AW-1:0] aperture_req,
  output logic result_valid,
  output logic signed [SW-1:0] volt_result,
  output logic signed [SW-1:0] curr_result,
  output logic volt_meas_over,
  output logic curr_meas_over,
  input wire smf_pkg::smf_src_t source_mode,
  input wire logic meas_autorange_en,
  input wire logic ar_aperture_auto,
  input wire logic [AW-1:0] ar_aperture_req,
  input wire logic [SW-1:0] ar_thresh_up,
  input wire logic [SW-1:0] ar_thresh_down,
  input wire logic [15:0] source_delay,
  input wire logic [16:0] max_range_delay,
  input wire logic meas_trig_req,
  output logic meas_trig,
  output logic meas_settling,
  output logic [$clog2(NR)-1:0] meas_range,
  input wire logic overrange_en,
  input wire logic volt_autorange_en,
  input wire logic curr_autorange_en,
  input wire logic [$clog2(NR)-1:0] volt_range_manual,
  input wire logic [$clog2(NR)-1:0] curr_range_manual,
  input wire logic sp_we,
  input wire logic sp_is_curr,
  input wire logic sp_is_limit,
  input wire logic [SW-1:0] sp_value,
  output logic [SW-1:0] volt_level,
  output logic [SW-1:0] volt_limit,
  output logic [SW-1:0] curr_level,
  output logic [SW-1:0] curr_limit,
  output logic [$clog2(NR)-1:0] volt_range,
  output logic [$clog2(NR)-1:0] curr_range,
  output logic sp_reject,
  input wire logic cmp_we,
  input wire smf_pkg::smf_cmp_sel_t cmp_sel,
  input wire logic cmp_cc,
  input wire logic [31:0] cmp_value,
  output logic [31:0] loop_unity_gain_freq_cv,
  output logic [31:0] loop_unity_gain_freq_cc,
  output logic [31:0] comp_freq_cv,
  output logic [31:0] comp_freq_cc,
  output logic [15:0] pole_zero_ratio_cv,
  output logic [15:0] pole_zero_ratio_cc,
  output logic cmp_reject
);
  import smf_pkg::*;

  localparam int IW = $clog2(NR);
  localparam int ACW = SW + 2 * AW;
  localparam int WW = 2 * AW;
  localparam int RW = SW + AW;

  typedef struct packed {
    smf_profile_t prof;
    logic [AW-1:0] len;
    logic [AW-1:0] pos;
    logic b_on;
    logic signed [ACW-1:0] acc_av;
    logic signed [ACW-1:0] acc_ai;
    logic signed [ACW-1:0] acc_bv;
    logic signed [ACW-1:0] acc_bi;
    logic [WW-1:0] ws_a;
    logic [WW-1:0] ws_b;
    logic div_go;
    logic signed [ACW-1:0] num_v;
    logic signed [ACW-1:0] num_i;
    logic [WW-1:0] den;
    logic res_valid;
    logic signed [SW-1:0] volt_res;
    logic signed [SW-1:0] curr_res;
    logic v_over;
    logic i_over;
    logic [AW-1:0] ar_pos;
    logic [RW-1:0] ar_acc;
    logic [IW-1:0] meas_range;
    logic [16:0] hold;
    logic settling;
    logic trig_pend;
    logic meas_trig;
    logic [SW-1:0] vlev;
    logic [SW-1:0] vlim;
    logic [SW-1:0] ilev;
    logic [SW-1:0] ilim;
    logic [IW-1:0] vrng;
    logic [IW-1:0] irng;
    logic sp_reject;
    logic [31:0] gbw_cv;
    logic [31:0] gbw_cc;
    logic [31:0] cf_cv;
    logic [31:0] cf_cc;
    logic [15:0] pz_cv;
    logic [15:0] pz_cc;
    logic cmp_reject;
  } smf_st_t;

  smf_st_t st, next_st;

  // Aperture in samples, a whole number of minimum units
  function automatic logic [AW-1:0] round_unit(input logic [AW-1:0] req);
    logic [AW:0] u;
    u = ({1'b0, req} + (AW+1)'(UNIT - 1)) / (AW+1)'(UNIT);
    if (u == '0) begin
      u = (AW+1)'(1);
    end
    return AW'(u * (AW+1)'(UNIT));
  endfunction

  function automatic logic [AW-1:0] weight(input logic [AW-1:0] p, input logic [AW-1:0] n,
                                           input smf_profile_t pr);
    logic [AW-1:0] h;
    h = n >> 1;
    if (pr == SMF_PROF_NORMAL) begin
      return AW'(1);
    end
    return (p < h) ? p + 1'b1 : n - p;
  endfunction

  function automatic logic signed [ACW-1:0] wprod(input logic signed [SW-1:0] s,
                                                  input logic [AW-1:0] w);
    return ACW'(s) * $signed({{(ACW-AW){1'b0}}, w});
  endfunction

  function automatic logic [SW-1:0] mag(input logic signed [SW-1:0] s);
    return s[SW-1] ? SW'(-s) : s;
  endfunction

  function automatic logic [SW-1:0] fs_of(input logic [NR*SW-1:0] tbl, input logic [IW-1:0] r);
    return tbl[r*SW +: SW];
  endfunction

  logic [AW-1:0] want_len, half, pos_b, w_a, w_b, ar_len;
  logic cfg_change, end_a, end_b, b_act, ar_end, rng_up, rng_dn;
  logic v_fits, i_fits, sp_fits, auto_on;
  logic [IW-1:0] v_best, i_best, best, manual;
  logic [NR*SW-1:0] sp_tbl;
  logic [RW-1:0] ar_add;
  logic [16:0] delay_want;
  logic signed [SW-1:0] q_v, q_i;
  logic dv_done;

  smf_div #(.NW(ACW), .DW(WW), .QW(SW)) u_div_v (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .start(st.div_go),
    .num(st.num_v),
    .den(st.den),
    .quo(q_v),
    .done(dv_done)
  );

  smf_div #(.NW(ACW), .DW(WW), .QW(SW)) u_div_i (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .start(st.div_go),
    .num(st.num_i),
    .den(st.den),
    .quo(q_i),
    .done()
  );

  smf_range_pick #(.NR(NR), .VW(SW), .IW(IW)) u_pick_v (
    .range_fs(V_RANGES),
    .overrange_en(overrange_en),
    .value(sp_value),
    .fits_any(v_fits),
    .best(v_best)
  );

  smf_range_pick #(.NR(NR), .VW(SW), .IW(IW)) u_pick_i (
    .range_fs(I_RANGES),
    .overrange_en(overrange_en),
    .value(sp_value),
    .fits_any(i_fits),
    .best(i_best)
  );

  always_comb begin
    next_st = st;
    next_st.div_go = 1'b0;
    next_st.res_valid = 1'b0;
    next_st.meas_trig = 1'b0;
    next_st.sp_reject = 1'b0;
    next_st.cmp_reject = 1'b0;

    // Averaging: lane a windows start at pos 0, lane b half an aperture later
    want_len = round_unit(aperture_req);
    half = st.len >> 1;
    pos_b = (st.pos >= half) ? st.pos - half : st.pos + half;
    w_a = weight(st.pos, st.len, st.prof);
    w_b = weight(pos_b, st.len, st.prof);
    b_act = (st.prof == SMF_PROF_SECOND) && (st.b_on || st.pos == half);
    end_a = st.pos == st.len - 1'b1;
    end_b = (st.prof == SMF_PROF_SECOND) && st.b_on && st.pos == half - 1'b1;
    cfg_change = (want_len != st.len) || (noise_profile != st.prof);
    if (!acq_run || cfg_change) begin
      // A new record: partial windows would mix old and new settings
      next_st.prof = noise_profile;
      next_st.len = want_len;
      next_st.pos = '0;
      next_st.b_on = 1'b0;
      next_st.acc_av = '0;
      next_st.acc_ai = '0;
      next_st.acc_bv = '0;
      next_st.acc_bi = '0;
      next_st.ws_a = '0;
      next_st.ws_b = '0;
    end else if (sample_valid) begin
      next_st.pos = end_a ? '0 : st.pos + 1'b1;
      next_st.acc_av = st.acc_av + wprod(volt_sample, w_a);
      next_st.acc_ai = st.acc_ai + wprod(curr_sample, w_a);
      next_st.ws_a = st.ws_a + WW'(w_a);
      if (b_act) begin
        next_st.b_on = 1'b1;
        next_st.acc_bv = st.acc_bv + wprod(volt_sample, w_b);
        next_st.acc_bi = st.acc_bi + wprod(curr_sample, w_b);
        next_st.ws_b = st.ws_b + WW'(w_b);
      end
      if (end_a) begin
        next_st.div_go = 1'b1;
        next_st.num_v = next_st.acc_av;
        next_st.num_i = next_st.acc_ai;
        next_st.den = next_st.ws_a;
        next_st.acc_av = '0;
        next_st.acc_ai = '0;
        next_st.ws_a = '0;
      end else if (end_b) begin
        next_st.div_go = 1'b1;
        next_st.num_v = next_st.acc_bv;
        next_st.num_i = next_st.acc_bi;
        next_st.den = next_st.ws_b;
        next_st.acc_bv = '0;
        next_st.acc_bi = '0;
        next_st.ws_b = '0;
      end
    end

    if (dv_done) begin
      next_st.res_valid = 1'b1;
      next_st.volt_res = q_v;
      next_st.curr_res = q_i;
      // Headroom is fixed, independent of the output overrange enable
      next_st.v_over = {1'b0, 32'(mag(q_v))} > smf_ovr_limit(32'(fs_of(V_RANGES,
        source_mode == SMF_SRC_VOLT ? st.vrng : st.meas_range)), 1'b1);
      next_st.i_over = {1'b0, 32'(mag(q_i))} > smf_ovr_limit(32'(fs_of(I_RANGES,
        source_mode == SMF_SRC_VOLT ? st.meas_range : st.irng)), 1'b1);
    end

    // Measurement autorange on the reading that is not being sourced
    ar_len = ar_aperture_auto ? st.len >> `SMF_AR_AUTO_SHIFT : round_unit(ar_aperture_req);
    if (ar_len == '0) begin
      ar_len = AW'(1);
    end
    ar_add = RW'(mag(source_mode == SMF_SRC_VOLT ? curr_sample : volt_sample));
    ar_end = st.ar_pos >= ar_len - 1'b1;
    rng_up = 1'b0;
    rng_dn = 1'b0;
    if (!acq_run || !meas_autorange_en) begin
      next_st.ar_pos = '0;
      next_st.ar_acc = '0;
    end else if (sample_valid) begin
      next_st.ar_acc = st.ar_acc + ar_add;
      next_st.ar_pos = st.ar_pos + 1'b1;
      if (ar_end) begin
        // Sum compared against threshold times length, no divide needed
        rng_up = next_st.ar_acc > RW'(ar_thresh_up * ar_len) && st.meas_range != IW'(NR - 1);
        rng_dn = next_st.ar_acc < RW'(ar_thresh_down * ar_len) && st.meas_range != '0;
        next_st.ar_pos = '0;
        next_st.ar_acc = '0;
      end
    end

    delay_want = 17'(`SMF_SETTLE_CYC) + 17'(source_delay);
    if (delay_want > max_range_delay) begin
      delay_want = max_range_delay;
    end
    if (rng_up || rng_dn) begin
      next_st.meas_range = rng_up ? st.meas_range + 1'b1 : st.meas_range - 1'b1;
      next_st.hold = delay_want;
    end else if (st.hold != '0) begin
      next_st.hold = st.hold - 1'b1;
    end
    next_st.settling = next_st.hold != '0;
    if (st.trig_pend && st.hold == '0 && !rng_up && !rng_dn) begin
      next_st.meas_trig = 1'b1;
      next_st.trig_pend = 1'b0;
    end
    if (meas_trig_req) begin
      next_st.trig_pend = 1'b1;
    end

    // Setpoint writes; range follows only here
    sp_tbl = sp_is_curr ? I_RANGES : V_RANGES;
    auto_on = sp_is_curr ? curr_autorange_en : volt_autorange_en;
    manual = sp_is_curr ? curr_range_manual : volt_range_manual;
    best = auto_on ? (sp_is_curr ? i_best : v_best) : manual;
    sp_fits = auto_on ? (sp_is_curr ? i_fits : v_fits) :
      {1'b0, 32'(sp_value)} <= smf_ovr_limit(32'(fs_of(sp_tbl, manual)), overrange_en);
    if (sp_we) begin
      if (!sp_fits) begin
        next_st.sp_reject = 1'b1;
      end else if (sp_is_curr) begin
        next_st.irng = best;
        if (sp_is_limit) begin
          next_st.ilim = sp_value;
        end else begin
          next_st.ilev = sp_value;
        end
      end else begin
        next_st.vrng = best;
        if (sp_is_limit) begin
          next_st.vlim = sp_value;
        end else begin
          next_st.vlev = sp_value;
        end
      end
    end

    if (cmp_we) begin
      case (cmp_sel)
        SMF_CMP_GBW: begin
          if (cmp_value < `SMF_GBW_MIN_HZ || cmp_value > `SMF_GBW_MAX_HZ) begin
            next_st.cmp_reject = 1'b1;
          end else if (cmp_cc) begin
            next_st.gbw_cc = cmp_value;
          end else begin
            next_st.gbw_cv = cmp_value;
          end
        end
        SMF_CMP_FREQ: begin
          if (cmp_value < `SMF_CFREQ_MIN_HZ || cmp_value > `SMF_CFREQ_MAX_HZ) begin
            next_st.cmp_reject = 1'b1;
          end else if (cmp_cc) begin
            next_st.cf_cc = cmp_value;
          end else begin
            next_st.cf_cv = cmp_value;
          end
        end
        SMF_CMP_PZ: begin
          if (cmp_value[31:16] != 16'h0000 || cmp_value[15:0] < `SMF_PZ_MIN ||
              cmp_value[15:0] > `SMF_PZ_MAX) begin
            next_st.cmp_reject = 1'b1;
          end else if (cmp_cc) begin
            next_st.pz_cc = cmp_value[15:0];
          end else begin
            next_st.pz_cv = cmp_value[15:0];
          end
        end
        default: next_st.cmp_reject = 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
      st.prof <= SMF_PROF_NORMAL;
      st.len <= AW'(UNIT);
      st.meas_range <= IW'(NR - 1);
      st.vrng <= IW'(NR - 1);
      st.irng <= IW'(NR - 1);
      st.gbw_cv <= `SMF_RST_GBW;
      st.gbw_cc <= `SMF_RST_GBW;
      st.cf_cv <= `SMF_RST_CFREQ;
      st.cf_cc <= `SMF_RST_CFREQ;
      st.pz_cv <= `SMF_RST_PZ;
      st.pz_cc <= `SMF_RST_PZ;
    end else begin
      st <= next_st;
    end
  end

  assign result_valid = st.res_valid;
  assign volt_result = st.volt_res;
  assign curr_result = st.curr_res;
  assign volt_meas_over = st.v_over;
  assign curr_meas_over = st.i_over;
  assign meas_trig = st.meas_trig;
  assign meas_settling = st.settling;
  assign meas_range = st.meas_range;
  assign volt_level = st.vlev;
  assign volt_limit = st.vlim;
  assign curr_level = st.ilev;
  assign curr_limit = st.ilim;
  assign volt_range = st.vrng;
  assign curr_range = st.irng;
  assign sp_reject = st.sp_reject;
  assign loop_unity_gain_freq_cv = st.gbw_cv;
  assign loop_unity_gain_freq_cc = st.gbw_cc;
  assign comp_freq_cv = st.cf_cv;
  assign comp_freq_cc = st.cf_cc;
  assign pole_zero_ratio_cv = st.pz_cv;
  assign pole_zero_ratio_cc = st.pz_cc;
  assign cmp_reject = st.cmp_reject;
endmodule

// ==== bench/smf_measure_filter_properties.sv ====
`timescale 1ns/1ps
module smf_chk #(
  parameter int NR = 4
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic result_valid,
  input wire logic meas_trig_req,
  input wire logic meas_trig,
  input wire logic meas_settling,
  input wire logic [$clog2(NR)-1:0] meas_range,
  input wire logic sp_we,
  input wire logic sp_is_curr,
  input wire logic sp_is_limit,
  input wire logic [23:0] sp_value,
  input wire logic [23:0] volt_level,
  input wire logic [$clog2(NR)-1:0] volt_range,
  input wire logic [$clog2(NR)-1:0] curr_range,
  input wire logic sp_reject,
  input wire logic cmp_we,
  input wire smf_pkg::smf_cmp_sel_t cmp_sel,
  input wire logic [31:0] cmp_value,
  input wire logic [31:0] loop_unity_gain_freq_cv,
  input wire logic cmp_reject
);
  import smf_pkg::*;
  // Largest output range with 5% headroom
  localparam logic [23:0] top_ovr = 24'h100590;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_req_idle;
    meas_trig_req && !meas_settling ##1 !meas_settling;
  endsequence
  sequence s_gbw_bad;
    cmp_we && cmp_sel == SMF_CMP_GBW && (cmp_value < 32'h0000000a || cmp_value > 32'h001e8480);
  endsequence
  sequence s_freq_bad;
    cmp_we && cmp_sel == SMF_CMP_FREQ && (cmp_value < 32'h00000032 || cmp_value > 32'h000f4240);
  endsequence
  chk_trig_after_req: assert property (s_req_idle |=> meas_trig)
    else $error("trigger missing after idle request");
  chk_trig_held_off: assert property (meas_settling |=> !meas_trig)
    else $error("trigger issued while settling");
  chk_range_settle: assert property ($changed(meas_range) |-> meas_settling)
    else $error("range change without hold-off");
  chk_range_step: assert property ($changed(meas_range) |->
      meas_range == $past(meas_range) + 1 || meas_range + 1 == $past(meas_range))
    else $error("measure range moved more than one step");
  chk_level_write: assert property (sp_we && !sp_is_curr && !sp_is_limit |=>
      sp_reject || volt_level == $past(sp_value))
    else $error("accepted level not stored");
  chk_sp_too_big: assert property (sp_we && sp_value > top_ovr |=> sp_reject && $stable(volt_range))
    else $error("oversized setpoint accepted");
  chk_reject_keep: assert property (sp_reject |-> $stable(volt_level) && $stable(curr_range))
    else $error("rejected setpoint changed state");
  chk_src_range_hold: assert property (!$past(sp_we) |-> $stable(volt_range) && $stable(curr_range))
    else $error("source range moved without a write");
  chk_gbw_refuse: assert property (s_gbw_bad |=> cmp_reject && $stable(loop_unity_gain_freq_cv))
    else $error("bad bandwidth accepted");
  chk_freq_refuse: assert property (s_freq_bad |=> cmp_reject)
    else $error("bad compensation frequency accepted");
  chk_cmp_quiet: assert property (!$past(cmp_we) |-> !cmp_reject && $stable(loop_unity_gain_freq_cv))
    else $error("compensation changed without a write");
  chk_result_single: assert property (result_valid |=> !result_valid)
    else $error("result strobe longer than one cycle");
endmodule

bind smf_measure_filter smf_chk #(.NR(NR)) u_chk (.*);

// ==== bench/smf_adc_model.sv ====
`timescale 1ns/1ps
module smf_adc_model #(
  parameter int GAP = 60
) (
  input wire logic sys_clk,
  output logic sample_valid,
  output logic signed [23:0] volt_sample,
  output logic signed [23:0] curr_sample
);
  initial begin
    sample_valid = 1'b0;
    volt_sample = 24'h5a5a5a;
    curr_sample = 24'ha5a5a5;
  end
  // Wide spacing keeps the divider clear of the next window end
  task automatic put(input logic signed [23:0] v, input logic signed [23:0] c);
    repeat (GAP) @(negedge sys_clk);
    sample_valid = 1'b1;
    volt_sample = v;
    curr_sample = c;
    @(negedge sys_clk);
    sample_valid = 1'b0;
    // Lines do not hold the last conversion after the strobe
    volt_sample = ~v;
    curr_sample = ~c;
  endtask
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import smf_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic acq_run, sample_valid, meas_autorange_en, ar_aperture_auto, meas_trig_req, overrange_en;
  logic volt_autorange_en, curr_autorange_en, sp_we, sp_is_curr, sp_is_limit, cmp_we, cmp_cc;
  logic signed [23:0] volt_sample, curr_sample, volt_result, curr_result;
  logic [23:0] ar_thresh_up, ar_thresh_down, sp_value, volt_level, volt_limit, curr_level, curr_limit;
  logic [15:0] aperture_req, ar_aperture_req, source_delay, pole_zero_ratio_cv, pole_zero_ratio_cc;
  logic [16:0] max_range_delay;
  logic [1:0] meas_range, volt_range_manual, curr_range_manual, volt_range, curr_range;
  logic [31:0] cmp_value, loop_unity_gain_freq_cv, loop_unity_gain_freq_cc, comp_freq_cv, comp_freq_cc;
  logic result_valid, volt_meas_over, curr_meas_over, meas_trig, meas_settling, sp_reject, cmp_reject;
  smf_profile_t noise_profile;
  smf_src_t source_mode;
  smf_cmp_sel_t cmp_sel;
  int bad_count = 0;
  int checks = 0;
  localparam logic [23:0] sp_val [7] = '{24'h0003e8, 24'h0003e9, 24'h00041a, 24'h00041b, 24'h100590,
    24'h100591, 24'h0001f4};
  localparam logic [1:0] sp_rng [7] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h3, 2'h3, 2'h0};
  localparam logic [6:0] sp_ovr = 7'b0111100;
  localparam logic [6:0] sp_rej = 7'b0100000;
  localparam logic [31:0] c_val [13] = '{32'h0000000a, 32'h00000009, 32'h001e8480, 32'h001e8481,
    32'h00000032, 32'h00000031, 32'h000f4240, 32'h000f4241, 32'h00000200, 32'h000001ff,
    32'h00008000, 32'h00008001, 32'h0000000a};
  localparam logic [12:0] c_cc = 13'b0011001100110;
  localparam logic [12:0] c_rej = 13'b1101010101010;
  logic [31:0] exp_reg [6] = '{32'h00002710, 32'h00002710, 32'h000003e8, 32'h000003e8, 32'h00001000,
    32'h00001000};

  smf_measure_filter u_dut (.*);
  smf_adc_model u_adc (.*);

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic wait_res;
    int i;
    for (i = 0; i < 200 && result_valid !== 1'b1; i++) tick(1);
    check(result_valid, 32'h1);
    if (i == 200) wrap_up();
  endtask

  task automatic feed(input logic signed [23:0] v, input int n);
    repeat (n) u_adc.put(v, 24'sh000000);
    wait_res();
  endtask

  task automatic sp_write(input logic cur, input logic lim, input logic [23:0] val);
    tick(1);
    sp_we = 1'b1;
    sp_is_curr = cur;
    sp_is_limit = lim;
    sp_value = val;
    tick(1);
    sp_we = 1'b0;
  endtask

  task automatic cmp_write(input logic [1:0] sel, input logic cc, input logic [31:0] val);
    tick(1);
    cmp_we = 1'b1;
    cmp_sel = smf_cmp_sel_t'(sel);
    cmp_cc = cc;
    cmp_value = val;
    tick(1);
    cmp_we = 1'b0;
  endtask

  function automatic logic [31:0] cmp_now(input int k);
    case (k)
      0: return loop_unity_gain_freq_cv;
      1: return loop_unity_gain_freq_cc;
      2: return comp_freq_cv;
      3: return comp_freq_cc;
      4: return {16'h0000, pole_zero_ratio_cv};
      default: return {16'h0000, pole_zero_ratio_cc};
    endcase
  endfunction

  task automatic cmp_all;
    for (int k = 0; k < 6; k++) check(cmp_now(k), exp_reg[k]);
  endtask

  // Counts the hold-off and checks a pended trigger waits it out
  task automatic settle(input int len);
    int n;
    int t;
    logic early;
    n = 0;
    early = 1'b0;
    for (t = 0; t < 5 && meas_settling !== 1'b1; t++) tick(1);
    meas_trig_req = 1'b1;
    while (meas_settling === 1'b1 && n < 400) begin
      tick(1);
      meas_trig_req = 1'b0;
      n++;
      if (meas_trig === 1'b1) early = 1'b1;
    end
    check(n, len);
    check(early, 32'h0);
    for (t = 0; t < 4 && meas_trig !== 1'b1; t++) tick(1);
    check(meas_trig, 32'h1);
  endtask

  initial begin
    int i;
    int k;
    logic [23:0] lvl;
    acq_run = 1'b0;
    noise_profile = SMF_PROF_NORMAL;
    aperture_req = 16'h0004;
    source_mode = SMF_SRC_VOLT;
    meas_autorange_en = 1'b0;
    ar_aperture_auto = 1'b1;
    ar_aperture_req = 16'h0004;
    ar_thresh_up = 24'h07a120;
    ar_thresh_down = 24'h000064;
    source_delay = 16'h000a;
    max_range_delay = 17'h0012c;
    meas_trig_req = 1'b0;
    overrange_en = 1'b0;
    volt_autorange_en = 1'b1;
    curr_autorange_en = 1'b0;
    volt_range_manual = 2'h3;
    curr_range_manual = 2'h2;
    sp_we = 1'b0;
    sp_is_curr = 1'b0;
    sp_is_limit = 1'b0;
    sp_value = 24'h000000;
    cmp_we = 1'b0;
    cmp_sel = SMF_CMP_GBW;
    cmp_cc = 1'b0;
    cmp_value = 32'h00000000;
    tick(5);
    sys_rst = 1'b0;
    check(volt_range, 32'h3);
    check(meas_range, 32'h3);
    check(volt_level, 32'h0);
    cmp_all();
    lvl = 24'h000000;
    for (i = 0; i < 7; i++) begin
      overrange_en = sp_ovr[i];
      sp_write(1'b0, 1'b0, sp_val[i]);
      if (!sp_rej[i]) lvl = sp_val[i];
      check(sp_reject, sp_rej[i]);
      check(volt_level, lvl);
      check(volt_range, sp_rng[i]);
    end
    sp_write(1'b1, 1'b1, 24'h0186a0);
    check(curr_limit, 32'h000186a0);
    check(curr_range, 32'h2);
    sp_write(1'b1, 1'b1, 24'h0186a1);
    check(sp_reject, 32'h1);
    check(curr_limit, 32'h000186a0);
    check(volt_range, 32'h0);
    for (i = 0; i < 13; i++) begin
      cmp_write(2'(i / 4), c_cc[i], c_val[i]);
      k = (i / 4) * 2 + int'(c_cc[i]);
      if (i < 12 && !c_rej[i]) exp_reg[k] = c_val[i];
      check(cmp_reject, c_rej[i]);
      cmp_all();
    end
    acq_run = 1'b1;
    u_adc.put(24'sh000001, -24'sh000001);
    u_adc.put(24'sh000002, -24'sh000002);
    u_adc.put(24'sh000003, -24'sh000003);
    u_adc.put(24'sh000006, -24'sh000007);
    wait_res();
    check(volt_result, 32'h3);
    check({8'h00, curr_result}, 32'h00fffffd);
    feed(24'sh00041a, 4);
    check(volt_meas_over, 32'h0);
    feed(24'sh00041b, 4);
    check(volt_meas_over, 32'h1);
    check(curr_meas_over, 32'h0);
    acq_run = 1'b0;
    noise_profile = SMF_PROF_SECOND;
    // Odd request must round up to the same window of four
    aperture_req = 16'h0003;
    tick(2);
    acq_run = 1'b1;
    u_adc.put(24'sh000004, 24'sh000000);
    u_adc.put(24'sh000008, 24'sh000000);
    u_adc.put(24'sh000008, 24'sh000000);
    u_adc.put(24'sh000004, 24'sh000000);
    wait_res();
    check(volt_result, 32'h6);
    feed(24'sh000000, 2);
    check(volt_result, 32'h2);
    acq_run = 1'b0;
    noise_profile = SMF_PROF_NORMAL;
    meas_autorange_en = 1'b1;
    tick(2);
    acq_run = 1'b1;
    u_adc.put(24'sh0f0000, 24'sh000005);
    settle(210);
    check(meas_range, 32'h2);
    max_range_delay = 17'h00032;
    u_adc.put(24'sh0f0000, -24'sh000005);
    settle(50);
    check(meas_range, 32'h1);
    source_mode = SMF_SRC_CURR;
    u_adc.put(24'sh000005, 24'sh0f0000);
    settle(50);
    check(meas_range, 32'h0);
    meas_trig_req = 1'b1;
    tick(1);
    meas_trig_req = 1'b0;
    tick(1);
    check(meas_trig, 32'h1);
    wrap_up();
  end
endmodule
